// ==== crt_bus_defines.svh ====
`ifndef CRT_BUS_DEFINES_SVH
`define CRT_BUS_DEFINES_SVH

// ----------------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------------
`define CLK_PERIOD_NS      10
`define WARN_MAX_NS        22840
`define WARN_MAX_CYC       ((`WARN_MAX_NS) / (`CLK_PERIOD_NS))
`define FETCH_NS           497
`define FETCH_CYC          ((`FETCH_NS) / (`CLK_PERIOD_NS))
`define DEAD_NS            250
`define DEAD_CYC           (((`DEAD_NS) + (`CLK_PERIOD_NS) - 1) / (`CLK_PERIOD_NS))
`define ACK_CYC            2
`define LINE_CYC           6356
`define HREF_CYC           8
`define FIELD_SEP_CYC      2000

// ----------------------------------------------------------------------------
// Reset values and sync modes
// ----------------------------------------------------------------------------
`define MODE_STANDALONE    2'h0
`define MODE_SIMPLE        2'h1
`define MODE_PLL           2'h2
`define REG_RESET          8'h00

`endif

// ==== crt_bus_pkg.sv ====
package crt_bus_pkg;
  typedef struct packed {
    logic        strobe;
    logic        write;
    logic [5:0]  addr;
    logic [7:0]  wdata;
  } reg_req_t;

  typedef struct packed {
    logic        req;
    logic [16:0] word_addr;
    logic [7:0]  words;
    logic [11:0] warn_cyc;
  } fetch_cmd_t;

  typedef enum logic [1:0] {
    SYNC_STANDALONE,
    SYNC_SIMPLE,
    SYNC_PLL
  } sync_mode_t;
endpackage

// ==== crt_reg_ram.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "crt_bus_defines.svh"

module crt_reg_ram #(
  parameter int AW = 6
) (
  input  wire logic          CORE_CLK,
  input  wire logic          we,
  input  wire logic [AW-1:0] addr,
  input  wire logic [7:0]    wdata,
  output logic      [7:0]    rdata
);
  logic [7:0] mem [0:(1<<AW)-1];

  always_ff @(posedge CORE_CLK) begin
    if (we) begin
      mem[addr] <= wdata;
    end
    rdata <= mem[addr];
  end
endmodule
`default_nettype wire

// ==== crt_sync.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "crt_bus_defines.svh"

module crt_sync (
  input  wire logic                    CORE_CLK,
  input  wire logic                    RST_N,
  input  wire crt_bus_pkg::sync_mode_t mode,
  input  wire logic                    csync_s,
  input  wire logic                    sepsync_s,
  output logic                         csync_out,
  output logic                         href_out,
  output logic                         field_sync,
  output logic                         hreset_pulse
);
  logic [12:0] hcnt_r;
  logic [4:0]  dead_r;
  logic        csync_d_r;
  logic        sep_d_r;
  logic [11:0] lowlen_r;
  logic        fall;
  logic        sep_src;
  logic [5:0]  since_r;

  assign fall = csync_d_r & ~csync_s;
  assign sep_src = (mode == crt_bus_pkg::SYNC_PLL) ? sepsync_s : csync_s;
  assign hreset_pulse = (mode == crt_bus_pkg::SYNC_SIMPLE) && fall && (dead_r == 5'h00);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      csync_d_r <= 1'b1;
      sep_d_r   <= 1'b1;
    end else begin
      csync_d_r <= csync_s;
      sep_d_r   <= sep_src;
    end
  end

  // Counter reset by sync edge, blanked by a dead time to stop jitter.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hcnt_r <= 13'h0000;
      dead_r <= 5'h00;
    end else if (hreset_pulse) begin
      hcnt_r <= 13'h0000;
      dead_r <= 5'(`DEAD_CYC);
    end else begin
      hcnt_r <= (hcnt_r == 13'(`LINE_CYC - 1)) ? 13'h0000 : hcnt_r + 13'h0001;
      if (dead_r != 5'h00) begin
        dead_r <= dead_r - 5'h01;
      end
    end
  end

  // Cycles since the last counter reset; it stops at its top value so it never wraps.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      since_r <= 6'h3F;
    end else if (hreset_pulse) begin
      since_r <= 6'h00;
    end else if (since_r != 6'h3F) begin
      since_r <= since_r + 6'h01;
    end
  end

  a_dead_time: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    hreset_pulse |-> since_r >= 6'(`DEAD_CYC))
    else $error("Counter reset inside dead time.");

  // Long low sync pulses mark the field; a line-sync pulse is far shorter.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      lowlen_r   <= 12'h000;
      field_sync <= 1'b0;
    end else begin
      field_sync <= 1'b0;
      if (sep_d_r) begin
        lowlen_r <= 12'h000;
      end else if (lowlen_r != 12'hFFF) begin
        lowlen_r <= lowlen_r + 12'h001;
      end
      if (!sep_d_r && lowlen_r == 12'(`FIELD_SEP_CYC)) begin
        field_sync <= 1'b1;
      end
    end
  end

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      csync_out <= 1'b1;
      href_out  <= 1'b0;
    end else begin
      csync_out <= (mode == crt_bus_pkg::SYNC_STANDALONE) ? (hcnt_r >= 13'(`HREF_CYC * 60)) : 1'b1;
      href_out  <= (mode == crt_bus_pkg::SYNC_PLL) && (hcnt_r < 13'(`HREF_CYC));
    end
  end
endmodule
`default_nettype wire

// ==== crt_ctrl_bus_and_sync_interface.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "crt_bus_defines.svh"

// How it works
// - Even bytes on upper half.
// - Word address equals upper byte, even only.
// - Display fetches outrank host; host yields.
// - Request spans warning plus access.
// - Warning programmable zero to 22.84 us.
// - Registers look like upper-byte RAM.
// - Strobe and write are inputs; select enables.
// - Register address taken from lower byte.
// - Acknowledge marks register transfer done.
// - Write-only mode input unused; register address always from low byte.
// - Passthrough buffer reaches lower memory byte.
// - Buffer passes when enabled, not during fetch cycles or (receive) register reads; host picks direction.
// - Stand-alone: own timing, composite sync out.
// - Simple slave: falling sync resets counter.
// - Dead time blocks repeated counter resets.
// - Simple slave field sync from separator.
// - Locked slave outputs horizontal reference.
// - Locked slave: vertical from separated sync.
// - Each fetch cycle lasts 49 clocks, 490 ns, not 497 ns.
// - Address strobe flags each memory cycle.
// - Both byte strobes asserted together.
// - Memory bus is read only.
module crt_ctrl_bus_and_sync_interface (
  input  wire logic                    CORE_CLK,
  input  wire logic                    RST_N,
  input  wire crt_bus_pkg::fetch_cmd_t FETCH_CMD,
  output logic                         FETCH_BUSY,
  output logic [15:0]                  FETCH_DATA,
  output logic                         FETCH_DATA_VALID,
  input  wire logic                    WRITE_ONLY_MODE,
  input  wire crt_bus_pkg::sync_mode_t SYNC_MODE,
  output logic                         MEMORY_BUS_REQUEST_N,
  output logic                         ADDRESS_STROBE_OUT_N,
  output logic                         UPPER_BYTE_STROBE_O_N,
  output logic                         UPPER_BYTE_STROBE_OE,
  input  wire logic                    UPPER_BYTE_STROBE_I_N,
  output logic                         LOWER_BYTE_STROBE_N,
  output logic                         RW_O,
  output logic                         RW_OE,
  input  wire logic                    RW_I,
  output logic [15:0]                  AD_O,
  output logic [15:0]                  AD_OE,
  input  wire logic [15:0]             AD_I,
  output logic [16:0]                  ADDR_HI_O,
  input  wire logic                    REGISTER_SELECT_N,
  output logic                         TRANSFER_ACKNOWLEDGE_N,
  input  wire logic                    PASSTHROUGH_BUFFER_ENABLE_N,
  input  wire logic                    SEND_RECEIVE_N,
  input  wire logic [7:0]              HOST_D_I,
  output logic [7:0]                   HOST_D_O,
  output logic                         HOST_D_OE,
  input  wire logic                    COMPOSITE_SYNC_LINE_I,
  output logic                         COMPOSITE_SYNC_LINE_O,
  output logic                         HORIZONTAL_REFERENCE_OUT,
  input  wire logic                    SEPARATED_SYNC_IN,
  output logic                         FIELD_SYNC,
  output logic                         HCOUNT_RESET
);
  // --------------------------------------------------------------------------
  // Pin synchronisers
  // --------------------------------------------------------------------------
  logic [6:0] s1_r;
  logic [6:0] s2_r;
  logic       rsel;
  logic       uds_in;
  logic       rw_in;
  logic       buf_en;
  logic       csync_s;
  logic       sep_s;
  logic       send_s;
  logic       buf_rx;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      s1_r <= 7'h7F;
      s2_r <= 7'h7F;
    end else begin
      s1_r <= {SEND_RECEIVE_N, SEPARATED_SYNC_IN, COMPOSITE_SYNC_LINE_I,
               PASSTHROUGH_BUFFER_ENABLE_N, RW_I, UPPER_BYTE_STROBE_I_N, REGISTER_SELECT_N};
      s2_r <= s1_r;
    end
  end

  assign rsel    = ~s2_r[0];
  assign uds_in  = ~s2_r[1];
  assign rw_in   = s2_r[2];
  assign buf_en  = ~s2_r[3];
  assign csync_s = s2_r[4];
  assign sep_s   = s2_r[5];
  assign send_s  = s2_r[6];

  // --------------------------------------------------------------------------
  // Display memory fetch engine
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {F_IDLE, F_WARN, F_CYCLE} fetch_state_t;
  fetch_state_t fst_r;
  logic [11:0]  warn_r;
  logic [5:0]   cyc_r;
  logic [7:0]   left_r;
  logic [16:0]  addr_r;
  logic         own_bus;
  logic         last_cyc;
  logic         host_rd;
  logic [7:0]   reg_rdata;

  function automatic logic [16:0] next_word(input logic [16:0] a);
    next_word = a + 17'h00002;
  endfunction

  assign own_bus    = (fst_r == F_CYCLE);
  assign FETCH_BUSY = (fst_r != F_IDLE);
  assign last_cyc   = own_bus && left_r == 8'h01 && cyc_r == 6'(`FETCH_CYC - 1);

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      fst_r  <= F_IDLE;
      warn_r <= 12'h000;
      cyc_r  <= 6'h00;
      left_r <= 8'h00;
      addr_r <= 17'h00000;
    end else begin
      case (fst_r)
        F_IDLE: begin
          if (FETCH_CMD.req && FETCH_CMD.words != 8'h00) begin
            addr_r <= {FETCH_CMD.word_addr[16:1], 1'b0};
            left_r <= FETCH_CMD.words;
            warn_r <= (FETCH_CMD.warn_cyc > 12'(`WARN_MAX_CYC)) ?
                      12'(`WARN_MAX_CYC) : FETCH_CMD.warn_cyc;
            cyc_r  <= 6'h00;
            fst_r  <= (FETCH_CMD.warn_cyc == 12'h000) ? F_CYCLE : F_WARN;
          end
        end
        F_WARN: begin
          if (warn_r <= 12'h001) begin
            fst_r <= F_CYCLE;
          end else begin
            warn_r <= warn_r - 12'h001;
          end
        end
        F_CYCLE: begin
          if (cyc_r == 6'(`FETCH_CYC - 1)) begin
            cyc_r  <= 6'h00;
            left_r <= left_r - 8'h01;
            addr_r <= next_word(addr_r);
            if (left_r == 8'h01) begin
              fst_r <= F_IDLE;
            end
          end else begin
            cyc_r <= cyc_r + 6'h01;
          end
        end
        default: fst_r <= F_IDLE;
      endcase
    end
  end

  // The host is assumed to yield on request; the fetch never waits.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      MEMORY_BUS_REQUEST_N  <= 1'b1;
      ADDRESS_STROBE_OUT_N  <= 1'b1;
      LOWER_BYTE_STROBE_N   <= 1'b1;
      FETCH_DATA            <= 16'h0000;
      FETCH_DATA_VALID      <= 1'b0;
    end else begin
      MEMORY_BUS_REQUEST_N <= !(FETCH_BUSY && !last_cyc);
      ADDRESS_STROBE_OUT_N <= !(own_bus && cyc_r >= 6'h02 &&
                              cyc_r < 6'(`FETCH_CYC - 1));
      LOWER_BYTE_STROBE_N  <= !(own_bus && cyc_r >= 6'h0A &&
                              cyc_r < 6'(`FETCH_CYC - 1));
      FETCH_DATA_VALID     <= own_bus && cyc_r == 6'(`FETCH_CYC - 2);
      if (own_bus && cyc_r == 6'(`FETCH_CYC - 2)) begin
        FETCH_DATA <= AD_I; // Upper half is the even byte.
      end
    end
  end

  a_strobes_paired: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    UPPER_BYTE_STROBE_OE |-> (UPPER_BYTE_STROBE_O_N == LOWER_BYTE_STROBE_N))
    else $error("Byte strobes not paired.");
  a_read_only: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    RW_OE |-> RW_O)
    else $error("Memory write issued.");
  a_float_outside: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !$past(own_bus) |-> (AD_OE[7:0] == ($past(buf_rx) ? 8'hFF : 8'h00)) && !RW_OE)
    else $error("Bus driven outside window.");
  a_req_covers: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    !ADDRESS_STROBE_OUT_N |-> !MEMORY_BUS_REQUEST_N)
    else $error("Strobe without request.");

  // Drive RW and strobe in the grant window only, AD also for register reads and buffer; address phase then data phase.
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      AD_O                  <= 16'h0000;
      AD_OE                 <= 16'h0000;
      ADDR_HI_O             <= 17'h00000;
      RW_O                  <= 1'b1;
      RW_OE                 <= 1'b0;
      UPPER_BYTE_STROBE_O_N <= 1'b1;
      UPPER_BYTE_STROBE_OE  <= 1'b0;
    end else begin
      RW_O                  <= 1'b1;
      RW_OE                 <= own_bus && !last_cyc;
      UPPER_BYTE_STROBE_OE  <= own_bus && !last_cyc;
      UPPER_BYTE_STROBE_O_N <= !(own_bus && cyc_r >= 6'h0A &&
                               cyc_r < 6'(`FETCH_CYC - 1));
      ADDR_HI_O             <= addr_r;
      if (own_bus && cyc_r < 6'h0A) begin
        AD_O  <= addr_r[16:1] << 1;
        AD_OE <= 16'hFFFF;
      end else if (host_rd) begin
        AD_O  <= {reg_rdata, 8'h00};
        AD_OE <= 16'hFF00;
      end else if (buf_rx) begin
        AD_O  <= {8'h00, HOST_D_I};
        AD_OE <= 16'h00FF;
      end else begin
        AD_O  <= 16'h0000;
        AD_OE <= 16'h0000;
      end
    end
  end

  // --------------------------------------------------------------------------
  // Host register port
  // --------------------------------------------------------------------------
  typedef enum logic [1:0] {H_IDLE, H_ACCESS, H_ACK} host_state_t;
  host_state_t       hst_r;
  logic [2:0]        ack_r;
  crt_bus_pkg::reg_req_t req_r;
  logic              ram_we;

  assign host_rd = (hst_r != H_IDLE) && !req_r.write;
  assign ram_we  = (hst_r == H_ACCESS) && req_r.write;

  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      hst_r <= H_IDLE;
      ack_r <= 3'h0;
      req_r <= '0;
      TRANSFER_ACKNOWLEDGE_N <= 1'b1;
    end else begin
      case (hst_r)
        H_IDLE: begin
          TRANSFER_ACKNOWLEDGE_N <= 1'b1;
          if (rsel && uds_in && !own_bus) begin
            req_r.strobe <= 1'b1;
            req_r.write  <= !rw_in;
            req_r.addr   <= AD_I[6:1];
            req_r.wdata  <= AD_I[15:8];
            ack_r        <= 3'(`ACK_CYC);
            hst_r        <= H_ACCESS;
          end
        end
        H_ACCESS: begin
          if (ack_r <= 3'h1) begin
            TRANSFER_ACKNOWLEDGE_N <= 1'b0;
            hst_r <= H_ACK;
          end else begin
            ack_r <= ack_r - 3'h1;
          end
        end
        H_ACK: begin
          if (!(rsel && uds_in)) begin
            TRANSFER_ACKNOWLEDGE_N <= 1'b1;
            req_r.strobe <= 1'b0;
            hst_r <= H_IDLE;
          end
        end
        default: hst_r <= H_IDLE;
      endcase
    end
  end

  a_ack_after_sel: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    $fell(TRANSFER_ACKNOWLEDGE_N) |-> $past(hst_r) == H_ACCESS)
    else $error("Acknowledge without access.");

  // Write-only hosts cannot read back; the read port still drives AD_O on any host read.
  crt_reg_ram #(.AW(6)) crt_reg_ram_inst (
    .CORE_CLK (CORE_CLK),
    .we       (ram_we),
    .addr     (req_r.addr),
    .wdata    (req_r.wdata),
    .rdata    (reg_rdata)
  );

  // --------------------------------------------------------------------------
  // Passthrough buffer to lower byte
  // --------------------------------------------------------------------------
  // The host gates the enable with its lowest address bit.
  assign buf_rx = buf_en && !send_s && !own_bus && !host_rd;
  always_ff @(posedge CORE_CLK or negedge RST_N) begin
    if (!RST_N) begin
      HOST_D_O  <= 8'h00;
      HOST_D_OE <= 1'b0;
    end else begin
      HOST_D_OE <= buf_en && !own_bus && send_s;
      HOST_D_O  <= AD_I[7:0];
    end
  end

  a_buffer_gated: assert property (@(posedge CORE_CLK) disable iff (!RST_N)
    HOST_D_OE |-> $past(buf_en) && !$past(own_bus))
    else $error("Buffer drove while disabled.");

  // --------------------------------------------------------------------------
  // Synchronisation
  // --------------------------------------------------------------------------
  logic csync_raw;
  assign COMPOSITE_SYNC_LINE_O = csync_raw;

  crt_sync crt_sync_inst (
    .CORE_CLK     (CORE_CLK),
    .RST_N        (RST_N),
    .mode         (SYNC_MODE),
    .csync_s      (csync_s),
    .sepsync_s    (sep_s),
    .csync_out    (csync_raw),
    .href_out     (HORIZONTAL_REFERENCE_OUT),
    .field_sync   (FIELD_SYNC),
    .hreset_pulse (HCOUNT_RESET)
  );

  logic unused_wo;
  assign unused_wo = WRITE_ONLY_MODE;
endmodule
`default_nettype wire

// ==== disp_mem_model.sv ====
`timescale 1ns/1ps
`default_nettype none
// ------------------------------------------------------------
// Display memory on the shared bus
// ------------------------------------------------------------
module disp_mem_model (
  input  wire logic        clk,
  input  wire logic        req_n,
  input  wire logic        as_n,
  input  wire logic        uds_n,
  input  wire logic        lds_n,
  input  wire logic        rw,
  input  wire logic [15:0] ad,
  output logic             oe,
  output logic      [15:0] d
);
  logic [15:0] lat;
  function automatic logic [7:0] pat(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  initial begin
    oe = 1'b0;
    d = 16'h0000;
  end
  // The external latch takes the address as the strobe falls.
  always @(negedge as_n) lat = ad;
  // A released bus flips every cycle, so stale data can never pass for a good word.
  always @(posedge clk) begin
    if (!req_n && !uds_n && !lds_n && rw) begin
      oe <= 1'b1;
      d <= {pat(lat), pat(lat | 16'h0001)};
    end else begin
      oe <= 1'b0;
      d <= ~d;
    end
  end
endmodule
`default_nettype wire

// ==== crt_ctrl_bus_and_sync_interface_bench.sv ====
`timescale 1ns/1ps
`default_nettype none
module crt_ctrl_bus_and_sync_interface_bench;
  logic                    clk = 1'b0;
  logic                    rst_n = 1'b0;
  crt_bus_pkg::fetch_cmd_t cmd = '0;
  crt_bus_pkg::sync_mode_t mode = crt_bus_pkg::SYNC_STANDALONE;
  logic                    wo = 1'b0, rsel_n = 1'b1, buf_n = 1'b1, sr_n = 1'b0;
  logic                    cs_i = 1'b1, sep = 1'b1, host_uds_n = 1'b1, host_rw = 1'b1;
  logic                    host_oe = 1'b0;
  logic [15:0]             host_ad = 16'h0000;
  logic [7:0]              host_d = 8'hA5;
  logic                    busy, fvalid, req_n, as_n, uds_o_n, uds_oe, lds_n, rw_o, rw_oe;
  logic                    ack_n, hd_oe, cs_o, href, fsync, hres, mem_oe, probe;
  logic [15:0]             fdata, ad_o, ad_oe, mem_d;
  logic [16:0]             addr_hi;
  logic [7:0]              hd_o, shadow [64];
  int                      error_cnt = 0, checked = 0, sel = 0;
  always #5 clk = ~clk;
  wire logic        uds_i_n = uds_oe ? uds_o_n : host_uds_n;
  wire logic        rw_i = rw_oe ? rw_o : host_rw;
  wire logic [15:0] other = mem_oe ? mem_d : (host_oe ? host_ad : mem_d);
  wire logic [15:0] ad_i = (ad_oe & ad_o) | (~ad_oe & other);
  always_comb begin
    case (sel)
      0: probe = hres;
      1: probe = fsync;
      2: probe = href;
      default: probe = cs_o;
    endcase
  end
  crt_ctrl_bus_and_sync_interface crt_ctrl_bus_and_sync_interface_inst (
    .CORE_CLK(clk), .RST_N(rst_n), .FETCH_CMD(cmd), .FETCH_BUSY(busy),
    .FETCH_DATA(fdata), .FETCH_DATA_VALID(fvalid), .WRITE_ONLY_MODE(wo),
    .SYNC_MODE(mode), .MEMORY_BUS_REQUEST_N(req_n), .ADDRESS_STROBE_OUT_N(as_n),
    .UPPER_BYTE_STROBE_O_N(uds_o_n), .UPPER_BYTE_STROBE_OE(uds_oe),
    .UPPER_BYTE_STROBE_I_N(uds_i_n), .LOWER_BYTE_STROBE_N(lds_n), .RW_O(rw_o),
    .RW_OE(rw_oe), .RW_I(rw_i), .AD_O(ad_o), .AD_OE(ad_oe), .AD_I(ad_i),
    .ADDR_HI_O(addr_hi), .REGISTER_SELECT_N(rsel_n), .TRANSFER_ACKNOWLEDGE_N(ack_n),
    .PASSTHROUGH_BUFFER_ENABLE_N(buf_n), .SEND_RECEIVE_N(sr_n), .HOST_D_I(host_d),
    .HOST_D_O(hd_o), .HOST_D_OE(hd_oe), .COMPOSITE_SYNC_LINE_I(cs_i),
    .COMPOSITE_SYNC_LINE_O(cs_o), .HORIZONTAL_REFERENCE_OUT(href),
    .SEPARATED_SYNC_IN(sep), .FIELD_SYNC(fsync), .HCOUNT_RESET(hres)
  );
  disp_mem_model disp_mem_model_inst (
    .clk(clk), .req_n(req_n), .as_n(as_n), .uds_n(uds_o_n), .lds_n(lds_n),
    .rw(rw_o), .ad(ad_o), .oe(mem_oe), .d(mem_d)
  );
  // ------------------------------------------------------------
  // Checking and closing
  // ------------------------------------------------------------
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("wrong value at %0t: %s seen %0h expected %0h", $time, what, seen, exp);
    end
  endtask
  task automatic print_verdict;
    if (error_cnt == 0 && checked > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  function automatic logic [7:0] exp_byte(input logic [15:0] a);
    return a[7:0] ^ 8'h5A;
  endfunction
  always @(negedge clk) begin
    if (rst_n && uds_oe) begin
      check(uds_o_n, lds_n, "byte strobes");
      check(rw_o, 1'b1, "read only");
    end
    if (rst_n && req_n) begin
      check({uds_oe, rw_oe}, 2'b00, "float");
    end
  end
  // ------------------------------------------------------------
  // Scenarios
  // ------------------------------------------------------------
  task automatic fetch(input logic [16:0] a, input logic [7:0] n, input logic [11:0] w);
    int low, k, as_at, lim;
    logic as_p;
    logic [16:0] e;
    low = 0;
    k = 0;
    as_at = -1;
    lim = 0;
    as_p = 1'b1;
    e = {a[16:1], 1'b0};
    @(posedge clk);
    cmd <= '{1'b1, a, n, w};
    @(posedge clk);
    cmd.req <= 1'b0;
    while (req_n !== 1'b0 && lim < 4) begin
      @(negedge clk);
      lim++;
    end
    check(req_n, 1'b0, "request");
    repeat (w + 49 * n + 8) begin
      if (req_n === 1'b0) low++;
      if (as_p === 1'b1 && as_n === 1'b0) begin
        check(ad_o, e[15:0], "address");
        check(addr_hi, e, "high address");
        if (as_at < 0) as_at = low;
      end
      if (fvalid === 1'b1) begin
        check(fdata, {exp_byte(e[15:0]), exp_byte(e[15:0] | 16'h1)}, "word");
        e = e + 17'h2;
        k++;
      end
      as_p = as_n;
      @(negedge clk);
    end
    check(k, n, "word count");
    check(as_at > w && as_at <= w + 5, 1'b1, "warning");
    check(low >= w + 49 * n - 1 && low <= w + 49 * n + 3, 1'b1, "span");
    check(busy, 1'b0, "busy");
  endtask
  task automatic reg_acc(input logic wr, input logic [5:0] a, input logic [7:0] wd);
    int t;
    t = 0;
    @(posedge clk);
    host_ad <= {wd, 1'b0, a, 1'b0};
    host_oe <= 1'b1;
    host_rw <= ~wr;
    rsel_n <= 1'b0;
    host_uds_n <= 1'b0;
    while (ack_n !== 1'b0 && t < 20) begin
      @(negedge clk);
      t++;
    end
    check(ack_n, 1'b0, "acknowledge");
    if (wr) shadow[a] = wd;
    else check(ad_o[15:8], shadow[a], "register read");
    @(posedge clk);
    rsel_n <= 1'b1;
    host_uds_n <= 1'b1;
    host_oe <= 1'b0;
    repeat (6) @(negedge clk);
    check(ack_n, 1'b1, "ack release");
  endtask
  task automatic no_select;
    @(posedge clk);
    host_uds_n <= 1'b0;
    host_rw <= 1'b0;
    repeat (12) begin
      @(negedge clk);
      check(ack_n, 1'b1, "unselected");
    end
    @(posedge clk);
    host_uds_n <= 1'b1;
  endtask
  task automatic buf_test;
    @(posedge clk);
    host_oe <= 1'b1;
    host_ad <= 16'h0096;
    buf_n <= 1'b0;
    sr_n <= 1'b1;
    repeat (4) @(negedge clk);
    check(hd_oe, 1'b1, "buffer drive");
    check(hd_o, 8'h96, "buffer data");
    @(posedge clk);
    sr_n <= 1'b0;
    repeat (4) @(negedge clk);
    check(hd_oe, 1'b0, "receive");
    check(ad_oe[7:0], 8'hFF, "receive drive");
    check(ad_o[7:0], host_d, "receive data");
    @(posedge clk);
    sr_n <= 1'b1;
    buf_n <= 1'b1;
    host_oe <= 1'b0;
    repeat (4) @(negedge clk);
    check(hd_oe, 1'b0, "disabled");
    check(ad_oe, 16'h0000, "buffer released");
  endtask
  task automatic watch(input int s, input int cycles, output int rises, output int run);
    int hi;
    logic last;
    sel = s;
    rises = 0;
    run = 0;
    hi = 0;
    @(negedge clk);
    last = probe;
    repeat (cycles) begin
      @(negedge clk);
      if (probe === 1'b1 && last === 1'b0) rises++;
      hi = (probe === 1'b1) ? hi + 1 : 0;
      if (hi > run) run = hi;
      last = probe;
    end
  endtask
  task automatic fall_cs(input int quiet, input int exp);
    int r, h;
    @(posedge clk);
    cs_i <= 1'b1;
    repeat (quiet) @(posedge clk);
    cs_i <= 1'b0;
    watch(0, 10, r, h);
    check(r, exp, "counter reset");
  endtask
  task automatic sync_test;
    int r, h;
    watch(3, 6400, r, h);
    check(r > 0, 1'b1, "composite sync out");
    @(posedge clk);
    mode <= crt_bus_pkg::SYNC_SIMPLE;
    fall_cs(4, 1);
    fall_cs(2, 0);
    fall_cs(30, 1);
    watch(1, 2100, r, h);
    check(r, 1, "field sync");
    @(posedge clk);
    mode <= crt_bus_pkg::SYNC_PLL;
    cs_i <= 1'b1;
    watch(2, 6400, r, h);
    check(r > 0, 1'b1, "reference pulse");
    check(h, 8, "reference width");
    @(posedge clk);
    sep <= 1'b0;
    watch(1, 2100, r, h);
    check(r, 1, "vertical reference");
  endtask
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (3) @(negedge clk);
    check({req_n, as_n, ack_n, uds_oe, rw_oe, hd_oe, ad_oe}, 22'h380000, "reset");
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    fetch(17'h00103, 8'h02, 12'h000);
    fetch(17'h1FFFE, 8'h01, 12'h005);
    reg_acc(1'b1, 6'h05, 8'h3C);
    wo <= 1'b1;
    reg_acc(1'b1, 6'h2A, 8'hC3);
    wo <= 1'b0;
    reg_acc(1'b0, 6'h05, 8'h00);
    reg_acc(1'b0, 6'h2A, 8'h00);
    no_select();
    buf_test();
    sync_test();
    print_verdict();
  end
  initial begin
    #400000;
    error_cnt++;
    print_verdict();
  end
endmodule
`default_nettype wire
